/* File: pbbd_bridge.sv */
`timescale 1ns/1ps
module pbbd_bridge
  import pbbd_pkg::*;
#(
  parameter int NUM_SEL = 64
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_req,
  input  wire logic                i_write,
  input  wire logic [31:0]         i_addr,
  input  wire logic [2:0]          i_size,
  input  wire logic [31:0]         i_wdata,
  output logic                     o_done,
  output logic [31:0]              o_rdata,
  output logic                     o_miss,
  output logic [NUM_SEL-1:0]       o_psel,
  output logic                     o_penable,
  output logic                     o_pwrite,
  output logic [31:0]              o_paddr,
  output logic [31:0]              o_pwdata,
  output logic [3:0]               o_pstrb,
  input  wire logic [31:0]         i_prdata,
  output logic [31:0]              o_bits
);

  // The top select is the interrupt controller; the rest must fit in the region's slots
  if (NUM_SEL < 2 || NUM_SEL > PBBD_NUM_SLOTS + 1) begin : g_bad_num_sel
    $error("NUM_SEL out of range");
  end

  typedef enum logic [1:0] {PBBD_IDLE, PBBD_SETUP, PBBD_ACCESS} pbbd_state_e;
  pbbd_state_e state;

  // Slot index inside the peripheral region; the last select is the interrupt controller
  function automatic logic [31:0] pbbd_slot(input logic [31:0] a);
    pbbd_slot = (a - PBBD_REGION_BASE) >> PBBD_WIN_BITS;
  endfunction : pbbd_slot

  function automatic logic [3:0] pbbd_lanes(input logic [2:0] sz, input logic [1:0] lo);
    case (sz)
      PBBD_SIZE_BYTE: pbbd_lanes = 4'h1 << lo;
      PBBD_SIZE_HALF: pbbd_lanes = lo[1] ? 4'hC : 4'h3;
      default:        pbbd_lanes = 4'hF;
    endcase
  endfunction : pbbd_lanes

  logic        hit_ic;
  logic        hit_per;
  logic [31:0] slot;
  logic [31:0] lane_data;
  assign hit_ic  = (i_addr[31:PBBD_IC_WIN_BITS] == PBBD_IC_BASE[31:PBBD_IC_WIN_BITS]);
  assign slot    = pbbd_slot(i_addr);
  assign hit_per = !hit_ic && (i_addr >= PBBD_REGION_BASE) && (slot < 32'(NUM_SEL - 1));
  // Replicate narrow data on every lane so the strobe picks the right byte
  assign lane_data = (i_size == PBBD_SIZE_BYTE) ? {4{i_wdata[7:0]}} :
                     (i_size == PBBD_SIZE_HALF) ? {2{i_wdata[15:0]}} : i_wdata;

  // A request still held in the done cycle is the one just served.
  // Taking it again would repeat the transfer, so that cycle is skipped.
  logic        take;
  assign take = (state == PBBD_IDLE) && i_req && !o_done;

  logic [31:0] pbits;
  logic        alias_sel;
  logic [13:0] alias_off;

  // Transfer sequencer: setup then access, one wait-free transfer per mapped request; an unmapped request gets no transfer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state     <= PBBD_IDLE;
      o_psel    <= '0;
      o_penable <= 1'b0;
      o_pwrite  <= 1'b0;
      o_paddr   <= 32'h0000_0000;
      o_pwdata  <= 32'h0000_0000;
      o_pstrb   <= 4'h0;
      o_done    <= 1'b0;
      o_miss    <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      alias_sel <= 1'b0;
      alias_off <= 14'h0000;
    end else begin
      o_done <= 1'b0;
      o_miss <= 1'b0;
      case (state)
        PBBD_IDLE: begin
          if (take && (hit_ic || hit_per)) begin
            state    <= PBBD_SETUP;
            o_psel   <= hit_ic ? (NUM_SEL'(1) << (NUM_SEL - 1)) : (NUM_SEL'(1) << slot[7:0]);
            o_pwrite <= i_write;
            // Base plus offset: only offset bits go to the peripheral
            o_paddr  <= hit_ic ? {20'h0_0000, i_addr[PBBD_IC_WIN_BITS-1:0]}
                               : {18'h0_0000, i_addr[PBBD_WIN_BITS-1:0]};
            o_pwdata <= lane_data;
            o_pstrb  <= i_write ? pbbd_lanes(i_size, i_addr[1:0]) : 4'h0;
            alias_sel <= hit_per && (slot == 32'h0000_0000);
            alias_off <= i_addr[PBBD_WIN_BITS-1:0];
          end else if (take) begin
            // Unmapped: answer at once with zero data
            o_done  <= 1'b1;
            o_miss  <= 1'b1;
            o_rdata <= 32'h0000_0000;
          end
        end
        PBBD_SETUP: begin
          state     <= PBBD_ACCESS;
          o_penable <= 1'b1;
        end
        PBBD_ACCESS: begin
          state     <= PBBD_IDLE;
          o_penable <= 1'b0;
          o_psel    <= '0;
          o_done    <= 1'b1;
          o_rdata   <= (alias_sel && alias_off[13:2] == PBBD_OFF_STAT[13:2]) ? pbits : i_prdata;
        end
        default: state <= PBBD_IDLE;
      endcase
    end
  end

  // Set/clear target register of slot 0; updated only in the access phase
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pbits <= PBBD_BIT_RST;
    end else if (state == PBBD_ACCESS && o_pwrite && alias_sel) begin
      for (int b = 0; b < 4; b++) begin
        if (o_pstrb[b]) begin
          if (alias_off[13:2] == PBBD_OFF_SET[13:2])
            pbits[8*b +: 8] <= pbits[8*b +: 8] | o_pwdata[8*b +: 8];
          else if (alias_off[13:2] == PBBD_OFF_CLR[13:2])
            pbits[8*b +: 8] <= pbits[8*b +: 8] & ~o_pwdata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_bits <= PBBD_BIT_RST;
    else       o_bits <= pbits;
  end

  AST_SETUP_TO_ACCESS: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == PBBD_SETUP) |=> o_penable && (o_psel != '0)) else $error("access phase missing");
  AST_DONE_TWO: assert property (@(posedge i_clk) disable iff (i_rst)
    (take && hit_per) |=> ##1 o_penable ##1 o_done) else $error("done late");
  AST_IC_SEL: assert property (@(posedge i_clk) disable iff (i_rst)
    (take && hit_ic) |=> o_psel[NUM_SEL-1]) else $error("ic select wrong");
  AST_OFFSET: assert property (@(posedge i_clk) disable iff (i_rst)
    (take && hit_per) |=> o_paddr[13:0] == $past(i_addr[13:0])) else $error("offset wrong");

  sequence pbbd_take_per;
    take && hit_per;
  endsequence

  sequence pbbd_take_miss;
    take && !hit_per && !hit_ic;
  endsequence

  AST_PER_SEL: assert property (@(posedge i_clk) disable iff (i_rst)
    pbbd_take_per |=> o_psel == (NUM_SEL'(1) << $past(slot[7:0])))
    else $error("peripheral select wrong");

  AST_ONE_HOT: assert property (@(posedge i_clk) disable iff (i_rst)
    $onehot0(o_psel)) else $error("more than one select");

  AST_MISS: assert property (@(posedge i_clk) disable iff (i_rst)
    pbbd_take_miss |=> o_done && o_miss && (o_psel == '0)) else $error("unmapped answer wrong");

  AST_MISS_WITH_DONE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_miss |-> o_done) else $error("miss without done");

  AST_DONE_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done |=> !o_done) else $error("done longer than one cycle");

  // Guards the done-cycle skip: a held request must not start a second transfer
  AST_NO_RETAKE: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == PBBD_IDLE && o_done) |=> state == PBBD_IDLE) else $error("request taken twice");

  AST_PSEL_DROP: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == PBBD_ACCESS) |=> (o_psel == '0) && !o_penable) else $error("select held after access");

  AST_RDATA_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_done |-> $stable(o_rdata)) else $error("read data moved without done");

  AST_READ_STRB: assert property (@(posedge i_clk) disable iff (i_rst)
    (pbbd_take_per and (!i_write)) |=> o_pstrb == 4'h0) else $error("strobe on read");

  AST_HALF_LANE: assert property (@(posedge i_clk) disable iff (i_rst)
    (take && i_write && hit_per && i_size == PBBD_SIZE_HALF)
    |=> o_pstrb == ($past(i_addr[1]) ? 4'hC : 4'h3)) else $error("half lane wrong");

  AST_WORD_DATA: assert property (@(posedge i_clk) disable iff (i_rst)
    (take && i_write && hit_per && i_size == PBBD_SIZE_WORD)
    |=> o_pwdata == $past(i_wdata) && o_pstrb == 4'hF) else $error("word data wrong");

  AST_BITS_FOLLOW: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> o_bits == $past(pbits)) else $error("register copy late");
  sequence pbbd_set_wr;
    state == PBBD_ACCESS && o_pwrite && alias_sel && alias_off == PBBD_OFF_SET && o_pstrb == 4'hF;
  endsequence
  sequence pbbd_clr_wr;
    state == PBBD_ACCESS && o_pwrite && alias_sel && alias_off == PBBD_OFF_CLR && o_pstrb == 4'hF;
  endsequence
  AST_SET: assert property (@(posedge i_clk) disable iff (i_rst)
    pbbd_set_wr |=> pbits == ($past(pbits) | $past(o_pwdata))) else $error("set alias wrong");
  AST_CLR: assert property (@(posedge i_clk) disable iff (i_rst)
    pbbd_clr_wr |=> pbits == ($past(pbits) & ~$past(o_pwdata))) else $error("clear alias wrong");
  AST_STAT: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == PBBD_ACCESS && !o_pwrite && alias_sel && alias_off == PBBD_OFF_STAT) |=> o_rdata == $past(pbits))
    else $error("read alias wrong");
  AST_BYTE_LANE: assert property (@(posedge i_clk) disable iff (i_rst)
    (take && i_write && hit_per && i_size == PBBD_SIZE_BYTE)
    |=> o_pstrb == (4'h1 << $past(i_addr[1:0]))) else $error("byte lane wrong");
  AST_STABLE_BITS: assert property (@(posedge i_clk) disable iff (i_rst)
    (state != PBBD_ACCESS) |=> pbits == $past(pbits)) else $error("bits changed outside access");

endmodule : pbbd_bridge

/* File: pbbd_periph.sv */
`timescale 1ns/1ps
module pbbd_periph (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sel,
  input  wire logic        i_penable,
  input  wire logic [31:0] i_paddr,
  output logic      [31:0] o_prdata
);
  // Zero wait states; outside access the bus toggles so stale data never matches
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_prdata <= 32'h0000_0000;
    else if (i_sel && !i_penable) o_prdata <= i_paddr ^ 32'hA5A5_0000;
    else o_prdata <= ~o_prdata;
  end
endmodule : pbbd_periph

/* File: pbbd_pkg.sv */
package pbbd_pkg;
  // Peripheral region: top 3 Mbyte of the 32-bit space
  localparam logic [31:0] PBBD_REGION_BASE  = 32'hFFD0_0000;
  localparam int          PBBD_WIN_BITS     = 14;   // 16 Kbyte window
  localparam int          PBBD_IC_WIN_BITS  = 12;   // 4 Kbyte window
  localparam logic [31:0] PBBD_IC_BASE      = 32'hFFFF_F000;
  localparam int          PBBD_NUM_SLOTS    = 192;  // 3 Mbyte / 16 Kbyte
  // Alias offsets of one bit-manipulated register inside a peripheral
  localparam logic [13:0] PBBD_OFF_SET      = 14'h0000;
  localparam logic [13:0] PBBD_OFF_CLR      = 14'h0004;
  localparam logic [13:0] PBBD_OFF_STAT     = 14'h0008;
  localparam logic [31:0] PBBD_BIT_RST      = 32'h0000_0000;
  localparam logic [2:0]  PBBD_SIZE_BYTE    = 3'h0;
  localparam logic [2:0]  PBBD_SIZE_HALF    = 3'h1;
  localparam logic [2:0]  PBBD_SIZE_WORD    = 3'h2;
endpackage : pbbd_pkg

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pbbd_pkg::*;
  logic        i_clk, i_rst, i_req, i_write, o_done, o_miss, o_penable, o_pwrite, miss_c, pw_c;
  logic [2:0]  i_size;
  logic [3:0]  o_pstrb, strb_c;
  logic [31:0] i_addr, i_wdata, o_rdata, o_paddr, o_pwdata, o_bits, i_prdata;
  logic [31:0] bits_m, paddr_c, pwd_c, rd_c, a, d;
  logic [63:0] o_psel, sel_c;
  int          mismatches, samples_checked, k;
  pbbd_bridge pbbd_bridge_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_write(i_write),
    .i_addr(i_addr), .i_size(i_size), .i_wdata(i_wdata), .o_done(o_done), .o_rdata(o_rdata),
    .o_miss(o_miss), .o_psel(o_psel), .o_penable(o_penable), .o_pwrite(o_pwrite),
    .o_paddr(o_paddr), .o_pwdata(o_pwdata), .o_pstrb(o_pstrb), .i_prdata(i_prdata), .o_bits(o_bits));
  pbbd_periph pbbd_periph_i (.i_clk(i_clk), .i_rst(i_rst), .i_sel(|o_psel), .i_penable(o_penable),
    .i_paddr(o_paddr), .o_prdata(i_prdata));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [31:0] ad, input logic [2:0] sz, input logic [31:0] wd);
    int n;
    @(posedge i_clk);
    i_req <= 1'b1;
    i_write <= w;
    i_addr <= ad;
    i_size <= sz;
    i_wdata <= wd;
    sel_c = '0;
    for (n = 0; n < 10; n++) begin
      @(negedge i_clk);
      if (|o_psel && !o_penable) begin
        sel_c = o_psel;
        paddr_c = o_paddr;
        pwd_c = o_pwdata;
        strb_c = o_pstrb;
        pw_c = o_pwrite;
      end
      if (o_done === 1'b1) break;
    end
    miss_c = o_miss;
    rd_c = o_rdata;
    if (n == 10) begin
      mismatches++;
      print_verdict();
    end
    // Dropped at the edge that sees done; the bridge still sees it held there and skips that cycle, so it is not taken twice
    @(posedge i_clk);
    i_req <= 1'b0;
  endtask : xfer
  initial begin
    {i_rst, i_req, i_write, i_addr, i_size, i_wdata} = {2'b10, 68'h0};
    {mismatches, samples_checked, bits_m} = '0;
    void'($urandom(32'hbd69be46));
    repeat (8) @(posedge i_clk);
    chk("bits_rst", o_bits, PBBD_BIT_RST);
    i_rst <= 1'b0;
    for (k = 0; k < 6; k++) begin
      d = $urandom;
      xfer(1'b1, PBBD_REGION_BASE + (k[0] ? PBBD_OFF_CLR : PBBD_OFF_SET), PBBD_SIZE_WORD, d);
      bits_m = k[0] ? (bits_m & ~d) : (bits_m | d);
      chk("psel0", sel_c, 64'h1);
      xfer(1'b0, PBBD_REGION_BASE + PBBD_OFF_STAT, PBBD_SIZE_WORD, 32'h0);
      chk("stat", rd_c, bits_m);
      chk("bits", o_bits, bits_m);
    end
    for (k = 0; k < 4; k++) begin
      a = PBBD_REGION_BASE + (k * 20 + 1) * 32'h4000 + ($urandom & 32'h3FF0) + ($urandom & (k[0] ? 2 : 3));
      d = $urandom;
      xfer(1'b1, a, k[0] ? PBBD_SIZE_HALF : PBBD_SIZE_BYTE, d);
      chk("psel", sel_c, 64'h1 << (k * 20 + 1));
      chk("paddr", paddr_c, a[13:0]);
      chk("strb", strb_c, k[0] ? 4'h3 << {a[1], 1'b0} : 4'h1 << a[1:0]);
      chk("pwdata", pwd_c, k[0] ? {2{d[15:0]}} : {4{d[7:0]}});
      chk("pwrite", pw_c, 1'b1);
      xfer(1'b0, a & ~32'h3, PBBD_SIZE_WORD, 32'h0);
      chk("pwrite_rd", pw_c, 1'b0);
      chk("rdata", rd_c, {18'h0, a[13:2], 2'h0} ^ 32'hA5A5_0000);
    end
    xfer(1'b0, PBBD_IC_BASE + 32'h104, PBBD_SIZE_WORD, 32'h0);
    chk("psel_ic", sel_c, 64'h1 << 63);
    xfer(1'b0, 32'h0010_0000, PBBD_SIZE_WORD, 32'h0);
    chk("miss", miss_c, 1'b1);
    chk("miss_sel", sel_c, 64'h0);
    chk("miss_rdata", rd_c, 32'h0000_0000);
    print_verdict();
  end
endmodule : tb_top
